/* verilog/pbclc_pkg.sv */
// Package for the bridge class/revision and latency/cache-line configuration words.
// Assumes a PCI configuration access port and the PCI bus clock.
package pbclc_pkg;
  localparam logic [15:0] PBCLC_OFS_CLASS_REV = 16'h2008;
  localparam logic [15:0] PBCLC_OFS_LAT_CLS = 16'h200C;
  localparam logic [7:0] PBCLC_BASE_CLASS = 8'h06;
  localparam logic [7:0] PBCLC_SUB_HOST = 8'h00;
  localparam logic [7:0] PBCLC_SUB_GUEST = 8'h80;
  // Revision and step numbers are arbitrary neutral values.
  localparam logic [3:0] PBCLC_REV_NUM = 4'h1;
  localparam logic [3:0] PBCLC_STEP_NUM = 4'h1;
  localparam logic [7:0] PBCLC_LAT_RST = 8'h00;
  localparam logic [7:0] PBCLC_CLS_RST = 8'h00;
  localparam logic [7:0] PBCLC_CLS_4 = 8'h04;
  localparam logic [7:0] PBCLC_CLS_8 = 8'h08;
  localparam logic [7:0] PBCLC_CLS_16 = 8'h10;
  localparam logic [7:0] PBCLC_CLS_32 = 8'h20;
  localparam int PBCLC_LAT_POS = 8;
  localparam int PBCLC_CLS_POS = 0;
  localparam int PBCLC_ALIGN_POS = 14;
  localparam logic [1:0] PBCLC_ALIGN_RST = 2'h0;
  typedef enum logic [2:0] {
    PBCLC_IDLE = 3'b001,
    PBCLC_RUN = 3'b010,
    PBCLC_EXPIRED = 3'b100
  } pbclc_state_t;
endpackage

/* verilog/pbclc_core.sv */
// Class/revision and latency/cache-line configuration words of the bridge, with the
// initiator latency counter. Assumes synchronous configuration strobes on sys_clk.
//
// How it works
// - Base class reads fixed bridge code 0x06.
// - Subclass follows host or guest strap.
// - Latency counter starts when FRAME# asserted.
// - Early FRAME# release ignores the counter.
// - Expired counter plus GNT# removal terminates.
// - Cache line sizes 4, 8, 16 accepted.
// - Unsupported size discarded and disables MWI.
// - Sizes other than 8,16,32 read zero.
// - Alignment bits steer cache-oriented commands.
`timescale 1ns/1ps
module pbclc_core
  import pbclc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic host_guest_strap,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [15:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0] cfg_be,
  output logic [31:0] cfg_rdata,
  input wire logic frame_active,
  input wire logic gnt_active,
  input wire logic [31:0] dma_bus_control_word,
  output logic term_req,
  output logic mwi_allowed,
  output logic [1:0] cache_align,
  output logic [7:0] lat_count
);
  import pbclc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  logic strap_reg, strap_next;
  logic [7:0] lat_reg, lat_next;
  logic [7:0] cls_reg, cls_next;
  logic mwi_reg, mwi_next;
  logic [1:0] align_reg, align_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] cnt_reg, cnt_next;
  logic term_reg, term_next;
  pbclc_state_t st_reg, st_next;
  logic cls_ok, cls_reads;
  logic [7:0] wr_cls;
  logic [31:0] class_word, lat_word;

  assign wr_cls = cfg_wdata[PBCLC_CLS_POS +: 8];
  // Supported sizes.
  // accepted size set
  assign cls_ok = (wr_cls == PBCLC_CLS_4) || (wr_cls == PBCLC_CLS_8) ||
                  (wr_cls == PBCLC_CLS_16);
  assign cls_reads = (cls_reg == PBCLC_CLS_8) || (cls_reg == PBCLC_CLS_16) ||
                     (cls_reg == PBCLC_CLS_32);
  assign class_word = {PBCLC_BASE_CLASS, strap_reg ? PBCLC_SUB_GUEST : PBCLC_SUB_HOST,
                       8'h00, PBCLC_REV_NUM, PBCLC_STEP_NUM};
  assign lat_word = {16'h0000, lat_reg, cls_reads ? cls_reg : 8'h00};

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers and read data.
  always_comb begin
    strap_next = host_guest_strap;
    lat_next = lat_reg;
    cls_next = cls_reg;
    mwi_next = mwi_reg;
    align_next = dma_bus_control_word[PBCLC_ALIGN_POS +: 2];
    rdata_next = rdata_reg;
    if (cfg_wr && cfg_addr == PBCLC_OFS_LAT_CLS) begin
      if (cfg_be[1]) begin
        lat_next = cfg_wdata[PBCLC_LAT_POS +: 8];
      end
      if (cfg_be[0]) begin
        if (cls_ok) begin
          cls_next = wr_cls;
          mwi_next = 1'b1;
        end else begin
          mwi_next = 1'b0;
        end
      end
    end
    if (cfg_rd) begin
      case (cfg_addr)
        PBCLC_OFS_CLASS_REV: begin
          rdata_next = class_word;
        end
        PBCLC_OFS_LAT_CLS: begin
          rdata_next = lat_word;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      strap_reg <= 1'b0;
      lat_reg <= PBCLC_LAT_RST;
      cls_reg <= PBCLC_CLS_RST;
      mwi_reg <= 1'b0;
      align_reg <= PBCLC_ALIGN_RST;
      rdata_reg <= 32'h0000_0000;
    end else begin
      strap_reg <= strap_next;
      lat_reg <= lat_next;
      cls_reg <= cls_next;
      mwi_reg <= mwi_next;
      align_reg <= align_next;
      rdata_reg <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Latency counter.
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    term_next = 1'b0;
    case (st_reg)
      PBCLC_IDLE: begin
        if (frame_active) begin
          cnt_next = lat_reg;
          st_next = (lat_reg == 8'h00) ? PBCLC_EXPIRED : PBCLC_RUN;
        end
      end
      PBCLC_RUN: begin
        if (!frame_active) begin
          st_next = PBCLC_IDLE;
          cnt_next = 8'h00;
        end else if (cnt_reg <= 8'h01) begin
          cnt_next = 8'h00;
          st_next = PBCLC_EXPIRED;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      PBCLC_EXPIRED: begin
        if (!frame_active) begin
          st_next = PBCLC_IDLE;
        end else begin
          term_next = !gnt_active;
        end
      end
      default: begin
        st_next = PBCLC_IDLE;
        cnt_next = 8'h00;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_reg <= PBCLC_IDLE;
      cnt_reg <= 8'h00;
      term_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      term_reg <= term_next;
    end
  end

  assign cfg_rdata = rdata_reg;
  assign term_req = term_reg;
  assign mwi_allowed = mwi_reg;
  assign cache_align = align_reg;
  assign lat_count = cnt_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_base_class;
    @(posedge sys_clk) disable iff (!nrst)
      cfg_rd && cfg_addr == PBCLC_OFS_CLASS_REV |=> cfg_rdata[31:24] == 8'h06;
  endproperty
  a_base_class: assert property (p_base_class) else $error("Base class wrong.");

  property p_subclass;
    @(posedge sys_clk) disable iff (!nrst)
      cfg_rd && cfg_addr == PBCLC_OFS_CLASS_REV |=>
        cfg_rdata[23:16] == ($past(strap_reg) ? 8'h80 : 8'h00);
  endproperty
  a_subclass: assert property (p_subclass) else $error("Subclass wrong.");

  property p_revstep;
    @(posedge sys_clk) disable iff (!nrst)
      cfg_rd && cfg_addr == PBCLC_OFS_CLASS_REV |=>
        cfg_rdata[15:0] == {8'h00, PBCLC_REV_NUM, PBCLC_STEP_NUM};
  endproperty
  a_revstep: assert property (p_revstep) else $error("Revision word wrong.");

  property p_lat_start;
    @(posedge sys_clk) disable iff (!nrst)
      st_reg == PBCLC_IDLE && frame_active |=> cnt_reg == $past(lat_reg);
  endproperty
  a_lat_start: assert property (p_lat_start) else $error("Counter not loaded.");

  property p_early_drop;
    @(posedge sys_clk) disable iff (!nrst)
      st_reg == PBCLC_RUN && !frame_active |=> st_reg == PBCLC_IDLE && !term_req;
  endproperty
  a_early_drop: assert property (p_early_drop) else $error("Early end not ignored.");

  sequence s_expired_gnt_lost;
    st_reg == PBCLC_EXPIRED && frame_active && !gnt_active;
  endsequence
  property p_term;
    @(posedge sys_clk) disable iff (!nrst) s_expired_gnt_lost |=> term_req;
  endproperty
  a_term: assert property (p_term) else $error("No termination.");

  property p_keep_burst;
    @(posedge sys_clk) disable iff (!nrst) term_req |-> !$past(gnt_active);
  endproperty
  a_keep_burst: assert property (p_keep_burst) else $error("Forced termination.");

  property p_cls_discard;
    @(posedge sys_clk) disable iff (!nrst)
      cfg_wr && cfg_addr == PBCLC_OFS_LAT_CLS && cfg_be[0] && !cls_ok |=>
        cls_reg == $past(cls_reg) && !mwi_allowed;
  endproperty
  a_cls_discard: assert property (p_cls_discard) else $error("Bad size kept.");

  property p_cls_zero;
    @(posedge sys_clk) disable iff (!nrst)
      cfg_rd && cfg_addr == PBCLC_OFS_LAT_CLS && !cls_reads |=> cfg_rdata[7:0] == 8'h00;
  endproperty
  a_cls_zero: assert property (p_cls_zero) else $error("Size not zeroed.");

  //////////////////////////////////////////////////////////////////////////////
  // Checks on field writes, read paths and counter steps.
  sequence s_lat_wr;
    cfg_wr && cfg_addr == PBCLC_OFS_LAT_CLS;
  endsequence

  sequence s_lat_rd;
    cfg_rd && cfg_addr == PBCLC_OFS_LAT_CLS;
  endsequence

  property p_lat_wr;
    @(posedge sys_clk) disable iff (!nrst)
      s_lat_wr ##0 cfg_be[1] |=>
        {16'h0000, lat_reg, 8'h00} == ($past(cfg_wdata) & 32'h0000_FF00);
  endproperty
  a_lat_wr: assert property (p_lat_wr) else $error("Latency byte not written.");

  property p_cls_accept;
    @(posedge sys_clk) disable iff (!nrst)
      s_lat_wr ##0 (cfg_be[0] && (cfg_wdata[7:0] == PBCLC_CLS_4 ||
        cfg_wdata[7:0] == PBCLC_CLS_8 || cfg_wdata[7:0] == PBCLC_CLS_16)) |=>
        mwi_allowed && {24'h000000, cls_reg} == ($past(cfg_wdata) & 32'h0000_00FF);
  endproperty
  a_cls_accept: assert property (p_cls_accept) else $error("Good size not taken.");

  property p_mwi_hold;
    @(posedge sys_clk) disable iff (!nrst)
      !(cfg_wr && cfg_addr == PBCLC_OFS_LAT_CLS && cfg_be[0]) |=>
        $stable(mwi_allowed) && $stable(cls_reg);
  endproperty
  a_mwi_hold: assert property (p_mwi_hold) else $error("Size state moved.");

  property p_lat_rd;
    @(posedge sys_clk) disable iff (!nrst)
      s_lat_rd |=> cfg_rdata[15:8] == $past(lat_reg) && cfg_rdata[31:16] == 16'h0000;
  endproperty
  a_lat_rd: assert property (p_lat_rd) else $error("Latency read wrong.");

  property p_cls_rd;
    @(posedge sys_clk) disable iff (!nrst)
      s_lat_rd ##0 (cls_reg == PBCLC_CLS_8 || cls_reg == PBCLC_CLS_16 ||
        cls_reg == PBCLC_CLS_32) |=> cfg_rdata[7:0] == $past(cls_reg);
  endproperty
  a_cls_rd: assert property (p_cls_rd) else $error("Size read wrong.");

  property p_lat_cnt;
    @(posedge sys_clk) disable iff (!nrst)
      st_reg == PBCLC_RUN && frame_active && cnt_reg > 8'h01 |=>
        lat_count == $past(cnt_reg) - 8'h01;
  endproperty
  a_lat_cnt: assert property (p_lat_cnt) else $error("Counter step wrong.");

  property p_expire;
    @(posedge sys_clk) disable iff (!nrst)
      st_reg == PBCLC_RUN && frame_active && cnt_reg <= 8'h01 |=>
        st_reg == PBCLC_EXPIRED && lat_count == 8'h00;
  endproperty
  a_expire: assert property (p_expire) else $error("Counter did not expire.");

  property p_lat_zero;
    @(posedge sys_clk) disable iff (!nrst)
      st_reg == PBCLC_IDLE && frame_active && lat_reg == 8'h00 |=> st_reg == PBCLC_EXPIRED;
  endproperty
  a_lat_zero: assert property (p_lat_zero) else $error("Zero timer not expired.");

  property p_term_src;
    @(posedge sys_clk) disable iff (!nrst)
      term_req |-> $past(st_reg) == PBCLC_EXPIRED && $past(frame_active);
  endproperty
  a_term_src: assert property (p_term_src) else $error("Termination too early.");

  property p_align;
    @(posedge sys_clk) disable iff (!nrst)
      1'b1 |=>
        {16'h0000, cache_align, 14'h0000} == ($past(dma_bus_control_word) & 32'h0000_C000);
  endproperty
  a_align: assert property (p_align) else $error("Alignment bits wrong.");
endmodule

/* dv/pbclc_pci_model.sv */
// PCI initiator and arbiter model driving FRAME# and GNT# levels.
// Assumes a one-cycle start pulse from the bench.
`timescale 1ns/1ps
module pbclc_pci_model (
  input wire logic sys_clk,
  input wire logic start,
  input wire logic [7:0] frame_len,
  input wire logic [7:0] gnt_len,
  output logic frame_active = 1'b0,
  output logic gnt_active = 1'b0
);
  int fcnt = 0;
  int gcnt = 0;
  always @(posedge sys_clk) begin
    if (start) begin
      fcnt = frame_len;
      gcnt = gnt_len;
    end else begin
      fcnt = (fcnt > 0) ? fcnt - 1 : 0;
      gcnt = (gcnt > 0) ? gcnt - 1 : 0;
    end
    frame_active <= (fcnt > 0);
    gnt_active <= (gcnt > 0);
  end
endmodule

/* dv/pbclc_core_test.sv */
// Self-checking bench for the class/revision and latency/cache-line words.
// Assumes pbclc_pkg, pbclc_core and pbclc_pci_model are compiled first.
`timescale 1ns/1ps
module pbclc_core_test;
  import pbclc_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic strap = 1'b0;
  logic cfg_rd = 1'b0;
  logic cfg_wr = 1'b0;
  logic [15:0] cfg_addr = 16'h0000;
  logic [31:0] cfg_wdata = 32'h00000000;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] dbcw = 32'h00000000;
  logic start = 1'b0;
  logic [7:0] frame_len = 8'h00;
  logic [7:0] gnt_len = 8'h00;
  logic [31:0] cfg_rdata;
  logic frame_active;
  logic gnt_active;
  logic term_req;
  logic mwi_allowed;
  logic [1:0] cache_align;
  logic [7:0] lat_count;
  localparam logic [15:0] rev_word = {8'h00, PBCLC_REV_NUM, PBCLC_STEP_NUM};
  logic [7:0] sz [4] = '{8'h04, 8'h08, 8'h05, 8'h10};
  logic [7:0] rb [4] = '{8'h00, 8'h08, 8'h08, 8'h10};
  logic mw [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  int bad_count = 0;
  int check_count = 0;
  always #2 sys_clk = ~sys_clk;
  pbclc_core DUT (.sys_clk(sys_clk), .nrst(nrst), .host_guest_strap(strap),
    .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_be(cfg_be), .cfg_rdata(cfg_rdata), .frame_active(frame_active),
    .gnt_active(gnt_active), .dma_bus_control_word(dbcw), .term_req(term_req),
    .mwi_allowed(mwi_allowed), .cache_align(cache_align), .lat_count(lat_count));
  pbclc_pci_model MDL (.sys_clk(sys_clk), .start(start), .frame_len(frame_len),
    .gnt_len(gnt_len), .frame_active(frame_active), .gnt_active(gnt_active));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
    @(negedge sys_clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    cfg_be = be;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    @(negedge sys_clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    chk32(cfg_rdata, exp);
  endtask
  task automatic run(input logic [7:0] fl, input logic [7:0] gl, input logic [7:0] lc,
                     input logic exp);
    logic seen;
    logic early;
    seen = 1'b0;
    early = 1'b0;
    @(negedge sys_clk);
    frame_len = fl;
    gnt_len = gl;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    @(negedge sys_clk);
    chk32({24'h000000, lat_count}, {24'h000000, lc});
    repeat (39) begin
      @(negedge sys_clk);
      if (gnt_active === 1'b1 && term_req !== 1'b0) early = 1'b1;
      if (term_req === 1'b1) seen = 1'b1;
    end
    chk1(early, 1'b0);
    chk1(seen, exp);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge sys_clk);
    nrst = 1'b1;
    chk1(term_req, 1'b0);
    chk1(mwi_allowed, 1'b0);
    rd_chk(PBCLC_OFS_CLASS_REV, {8'h06, 8'h00, rev_word});
    strap = 1'b1;
    wr(PBCLC_OFS_CLASS_REV, 32'hFFFFFFFF, 4'hF);
    rd_chk(PBCLC_OFS_CLASS_REV, {8'h06, 8'h80, rev_word});
    rd_chk(16'h2010, 32'h00000000);
    wr(PBCLC_OFS_LAT_CLS, 32'h00000300, 4'h2);
    for (int i = 0; i < 4; i++) begin
      wr(PBCLC_OFS_LAT_CLS, {24'h000000, sz[i]}, 4'h1);
      @(negedge sys_clk);
      chk1(mwi_allowed, mw[i]);
      rd_chk(PBCLC_OFS_LAT_CLS, {16'h0000, 8'h03, rb[i]});
    end
    // Alignment chosen by software from the 16-word size.
    dbcw = 32'h00008000;
    repeat (2) @(negedge sys_clk);
    chk32({30'h0, cache_align}, 32'h00000002);
    run(8'd30, 8'd12, 8'h03, 1'b1);
    wr(PBCLC_OFS_LAT_CLS, 32'h00001400, 4'h2);
    run(8'd4, 8'd2, 8'h14, 1'b0);
    wr(PBCLC_OFS_LAT_CLS, 32'h00000000, 4'h2);
    run(8'd20, 8'd0, 8'h00, 1'b1);
    print_verdict();
  end
endmodule
